/* File: hw/uacm_pkg.sv */
/*
 * uacm_pkg: constants and carrier types for the UART control-option,
 * interrupt-gating, infrared-select and multidrop address-compare block.
 * assumes: one clock domain, APB with 32-bit data, byte address = 4 x index.
 */
package uacm_pkg;

    // ------------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] UACM_IDX_RXDATA = 12'hf40;
    localparam logic [11:0] UACM_IDX_CTL0   = 12'hf42;
    localparam logic [11:0] UACM_IDX_CTL1   = 12'hf43;
    localparam logic [11:0] UACM_IDX_NODE   = 12'hf45;
    localparam logic [11:0] UACM_IDX_BRH    = 12'hf46;
    localparam logic [11:0] UACM_IDX_BRL    = 12'hf47;
    localparam logic [11:0] UACM_IDX_IRQST  = 12'hf50;
    localparam logic [11:0] UACM_IDX_IRQMSK = 12'hf51;

    localparam logic [15:0] UACM_ADDR_RXDATA = {2'b00, UACM_IDX_RXDATA, 2'b00};
    localparam logic [15:0] UACM_ADDR_CTL0   = {2'b00, UACM_IDX_CTL0, 2'b00};
    localparam logic [15:0] UACM_ADDR_CTL1   = {2'b00, UACM_IDX_CTL1, 2'b00};
    localparam logic [15:0] UACM_ADDR_NODE   = {2'b00, UACM_IDX_NODE, 2'b00};
    localparam logic [15:0] UACM_ADDR_BRH    = {2'b00, UACM_IDX_BRH, 2'b00};
    localparam logic [15:0] UACM_ADDR_BRL    = {2'b00, UACM_IDX_BRL, 2'b00};
    localparam logic [15:0] UACM_ADDR_IRQST  = {2'b00, UACM_IDX_IRQST, 2'b00};
    localparam logic [15:0] UACM_ADDR_IRQMSK = {2'b00, UACM_IDX_IRQMSK, 2'b00};

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  UACM_RST_CTL0    = 8'h00;
    localparam logic [7:0]  UACM_RST_CTL1    = 8'h00;
    localparam logic [7:0]  UACM_RST_NODE    = 8'h00;
    localparam logic [7:0]  UACM_RST_BRH     = 8'hff;
    localparam logic [7:0]  UACM_RST_BRL     = 8'hff;
    localparam logic [2:0]  UACM_RST_IRQ     = 3'h0;
    localparam int          UACM_CTL0_RXEN   = 6;
    localparam int          UACM_IRQ_DATA    = 0;
    localparam int          UACM_IRQ_ERR     = 1;
    localparam int          UACM_IRQ_TIMER   = 2;
    localparam int          UACM_IRQ_BITS    = 3;

    // multidrop interrupt modes, {ctl1[7], ctl1[5]}
    localparam logic [1:0]  UACM_MP_ALL      = 2'h0;
    localparam logic [1:0]  UACM_MP_ADDR     = 2'h1;
    localparam logic [1:0]  UACM_MP_MATCH    = 2'h2;
    localparam logic [1:0]  UACM_MP_DATA     = 2'h3;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic mpModeHi;
        logic mpEnable;
        logic mpModeLo;
        logic mpBitTx;
        logic dePolarity;
        logic baudTimerSelect;
        logic dataIrqSuppress;
        logic infraredCodecOn;
    } uacm_ctl1_type;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } uacm_rxbyte_type;

endpackage : uacm_pkg

/* File: hw/uacm_baud_gen.sv */
/*
 * uacm_baud_gen: 16-bit down-counting baud divisor with periodic reload.
 * assumes: divisor is held stable by software while it runs; runs every clock.
 */
`timescale 1ns/100ps
module uacm_baud_gen #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] reload,
    input  wire logic             restart,
    output logic      [WIDTH-1:0] count,
    output logic                  zeroHit
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // a divisor of 1 hits zero every clock; interval = period x divisor
    assign zeroHit = (count_reg == WIDTH'(1)) || (count_reg == '0);
    assign count   = count_reg;

    always_comb begin
        if (restart || zeroHit) begin
            count_next = reload; // [RULE_14]
        end else begin
            count_next = count_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '1;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reload_on_zero_a : assert property (zeroHit && !restart |=> count_reg == $past(reload)) // [RULE_14]
        else $error("baud counter did not reload at zero");
    count_down_a : assert property (!zeroHit && !restart |=> count_reg == $past(count_reg) - WIDTH'(1))
        else $error("baud counter did not count down");

endmodule : uacm_baud_gen

/* File: hw/uacm_top.sv */
/*
 * uacm_top: baud-timer option, receive interrupt gating, infrared select
 * and multidrop node-address compare for one UART, with an APB slave.
 * assumes: the receiver delivers each byte as a one-cycle rxValid pulse with
 * its ninth bit, errors as a one-cycle rxError pulse; an external codec
 * supplies encoded and decoded serial lines; all inputs synchronous to clk.
 */
// Functional notes
// [RULE_01] rx off, select 0: divisor reads reload
// [RULE_02] rx off, select 1: zero count interrupts
// [RULE_03] rx off, select 1: divisor reads live count
// [RULE_04] rx on: select steers reads only
// [RULE_05] each byte read is live, unlatched
// [RULE_06] suppress 0: data and errors interrupt
// [RULE_07] suppress 1: only errors interrupt
// [RULE_08] codec enable routes serial through infrared
// [RULE_09] compare mode checks every address byte
// [RULE_10] compare mode: irq and avail only on match
// [RULE_11] node match is 8-bit RW, reset zero
// [RULE_12] receiver enable selects select-bit behaviour
// [RULE_13] mode 10 match-through, 11 data only
// [RULE_14] timer reloads at zero, keeps counting
`timescale 1ns/100ps
module uacm_top (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [15:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       rxValid,
    input  wire uacm_pkg::uacm_rxbyte_type  rxByte,
    input  wire logic                       rxError,
    output logic                            rxEnable,
    output logic                            rxDataAvail,
    input  wire logic                       txRaw,
    input  wire logic                       txEncoded,
    output logic                            pinTxd,
    input  wire logic                       pinRxd,
    input  wire logic                       rxDecoded,
    output logic                            rxSerial,
    output logic                            infraredCodecOn,
    output logic                            irq
);

    // ------------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------------
    logic [7:0]                  ctl0_reg;
    uacm_pkg::uacm_ctl1_type     ctl1_reg;
    logic [7:0]                  nodeMatch_reg;
    logic [7:0]                  brh_reg;
    logic [7:0]                  brl_reg;
    logic [7:0]                  rxData_reg;
    logic                        rxAvail_reg;
    logic                        matched_reg;
    logic [2:0]                  status_reg;
    logic [2:0]                  status_next;
    logic [2:0]                  mask_reg;
    logic [31:0]                 prdata_reg;
    logic                        pslverr_reg;
    logic                        pinTxd_reg;
    logic                        rxSerial_reg;
    logic                        setupPhase;
    logic                        accessPhase;
    logic                        wrAccess;
    logic                        rdAccess;
    logic                        lane0;
    logic                        mapped;
    logic [31:0]                 readMux;
    logic [15:0]                 baudCount;
    logic                        baudZero;
    logic                        baudRestart;
    logic                        baudRestart_reg;
    logic                        rxOn;
    logic                        liveRead;
    logic                        timerEvent;
    logic [1:0]                  mpMode;
    logic                        isAddr;
    logic                        addrMatch;
    logic                        deliver;
    logic                        acceptByte;
    logic                        dataEvent;
    logic                        errEvent;
    logic [2:0]                  eventSet;
    logic [2:0]                  clearBits;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess    = accessPhase && pwrite && !pslverr_reg;
    assign rdAccess    = accessPhase && !pwrite && !pslverr_reg;
    assign lane0       = pstrb[0];
    // every access completes in one access cycle, no wait states
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && pslverr_reg;
    assign prdata      = prdata_reg;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            uacm_pkg::UACM_ADDR_RXDATA,
            uacm_pkg::UACM_ADDR_CTL0,
            uacm_pkg::UACM_ADDR_CTL1,
            uacm_pkg::UACM_ADDR_NODE,
            uacm_pkg::UACM_ADDR_BRH,
            uacm_pkg::UACM_ADDR_BRL,
            uacm_pkg::UACM_ADDR_IRQST,
            uacm_pkg::UACM_ADDR_IRQMSK: mapped = 1'b1;
            default:                    mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // software must not rewrite the controls while the uart runs; no guard here
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl0_reg <= uacm_pkg::UACM_RST_CTL0;
            ctl1_reg <= uacm_pkg::UACM_RST_CTL1;
            mask_reg <= uacm_pkg::UACM_RST_IRQ;
        end else if (wrAccess && lane0) begin
            if (paddr == uacm_pkg::UACM_ADDR_CTL0) begin
                ctl0_reg <= pwdata[7:0];
            end
            if (paddr == uacm_pkg::UACM_ADDR_CTL1) begin
                ctl1_reg <= pwdata[7:0];
            end
            if (paddr == uacm_pkg::UACM_ADDR_IRQMSK) begin
                mask_reg <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nodeMatch_reg <= uacm_pkg::UACM_RST_NODE; // [RULE_11]
        end else if (wrAccess && lane0 && paddr == uacm_pkg::UACM_ADDR_NODE) begin
            nodeMatch_reg <= pwdata[7:0]; // [RULE_11]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            brh_reg <= uacm_pkg::UACM_RST_BRH;
            brl_reg <= uacm_pkg::UACM_RST_BRL;
        end else if (wrAccess && lane0) begin
            if (paddr == uacm_pkg::UACM_ADDR_BRH) begin
                brh_reg <= pwdata[7:0];
            end
            if (paddr == uacm_pkg::UACM_ADDR_BRL) begin
                brl_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // baud generator and timer use
    // ------------------------------------------------------------------
    assign rxOn        = ctl0_reg[uacm_pkg::UACM_CTL0_RXEN]; // [RULE_12]
    assign rxEnable    = rxOn;
    assign liveRead    = ctl1_reg.baudTimerSelect; // [RULE_01] [RULE_03] [RULE_04]
    // restart one edge after a divisor write, once the new byte is stored;
    // restarting on the write edge itself would load the old divisor
    always_ff @(posedge clk) begin
        if (rst) begin
            baudRestart_reg <= 1'b0;
        end else begin
            baudRestart_reg <= wrAccess && lane0
                && (paddr == uacm_pkg::UACM_ADDR_BRH || paddr == uacm_pkg::UACM_ADDR_BRL);
        end
    end
    assign baudRestart = baudRestart_reg;
    // the counter only interrupts in timer use, never while receiving
    assign timerEvent  = baudZero && !rxOn && ctl1_reg.baudTimerSelect; // [RULE_02] [RULE_04]

    uacm_baud_gen #(
        .WIDTH (16)
    ) u_baud (
        .clk     (clk),
        .rst     (rst),
        .reload  ({brh_reg, brl_reg}),
        .restart (baudRestart),
        .count   (baudCount),
        .zeroHit (baudZero)
    );

    // ------------------------------------------------------------------
    // receive path: multidrop compare and interrupt gating
    // ------------------------------------------------------------------
    assign mpMode     = {ctl1_reg.mpModeHi, ctl1_reg.mpModeLo};
    assign isAddr     = ctl1_reg.mpEnable && rxByte.ninth;
    assign addrMatch  = rxByte.data == nodeMatch_reg; // [RULE_11]
    assign acceptByte = rxValid && rxOn;

    always_comb begin
        deliver = 1'b1;
        if (ctl1_reg.mpEnable) begin
            case (mpMode)
                uacm_pkg::UACM_MP_ALL:   deliver = 1'b1;
                uacm_pkg::UACM_MP_ADDR:  deliver = isAddr;
                uacm_pkg::UACM_MP_MATCH: deliver = isAddr ? addrMatch : matched_reg; // [RULE_13]
                uacm_pkg::UACM_MP_DATA:  deliver = !isAddr && matched_reg; // [RULE_13]
                default:                 deliver = 1'b1;
            endcase
        end
    end

    // in compare modes nothing lands unless the node matched
    assign dataEvent = acceptByte && deliver && !ctl1_reg.dataIrqSuppress; // [RULE_06] [RULE_07] [RULE_10]
    assign errEvent  = rxError && rxOn; // [RULE_06] [RULE_07]

    always_ff @(posedge clk) begin
        if (rst) begin
            matched_reg <= 1'b0;
        end else if (acceptByte && isAddr && ctl1_reg.mpModeHi) begin
            matched_reg <= addrMatch; // [RULE_09]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxData_reg <= 8'h00;
        end else if (acceptByte && (deliver || !ctl1_reg.mpModeHi)) begin
            rxData_reg <= rxByte.data;
        end
    end

    // set wins over the clear that a data read makes
    always_ff @(posedge clk) begin
        if (rst) begin
            rxAvail_reg <= 1'b0;
        end else if (acceptByte && (deliver || !ctl1_reg.mpModeHi)) begin
            rxAvail_reg <= 1'b1; // [RULE_10]
        end else if (rdAccess && paddr == uacm_pkg::UACM_ADDR_RXDATA) begin
            rxAvail_reg <= 1'b0;
        end
    end
    assign rxDataAvail = rxAvail_reg;

    // ------------------------------------------------------------------
    // interrupt status and output
    // ------------------------------------------------------------------
    always_comb begin
        eventSet                            = 3'h0;
        eventSet[uacm_pkg::UACM_IRQ_DATA]   = dataEvent;
        eventSet[uacm_pkg::UACM_IRQ_ERR]    = errEvent;
        eventSet[uacm_pkg::UACM_IRQ_TIMER]  = timerEvent;
        clearBits = (wrAccess && lane0 && paddr == uacm_pkg::UACM_ADDR_IRQST) ? pwdata[2:0] : 3'h0;
        status_next = (status_reg & ~clearBits) | eventSet;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg <= uacm_pkg::UACM_RST_IRQ;
        end else begin
            status_reg <= status_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ------------------------------------------------------------------
    // serial routing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pinTxd_reg   <= 1'b1;
            rxSerial_reg <= 1'b1;
        end else begin
            pinTxd_reg   <= ctl1_reg.infraredCodecOn ? txEncoded : txRaw; // [RULE_08]
            rxSerial_reg <= ctl1_reg.infraredCodecOn ? rxDecoded : pinRxd; // [RULE_08]
        end
    end
    assign pinTxd          = pinTxd_reg;
    assign rxSerial        = rxSerial_reg;
    assign infraredCodecOn = ctl1_reg.infraredCodecOn;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // each half reads the counter as it stands; no high-byte snapshot
    always_comb begin
        readMux = 32'h0;
        case (paddr)
            uacm_pkg::UACM_ADDR_RXDATA: readMux[7:0] = rxData_reg;
            uacm_pkg::UACM_ADDR_CTL0:   readMux[7:0] = ctl0_reg;
            uacm_pkg::UACM_ADDR_CTL1:   readMux[7:0] = ctl1_reg;
            uacm_pkg::UACM_ADDR_NODE:   readMux[7:0] = nodeMatch_reg;
            uacm_pkg::UACM_ADDR_BRH:    readMux[7:0] = liveRead ? baudCount[15:8] : brh_reg; // [RULE_05]
            uacm_pkg::UACM_ADDR_BRL:    readMux[7:0] = liveRead ? baudCount[7:0] : brl_reg; // [RULE_05]
            uacm_pkg::UACM_ADDR_IRQST:  readMux[2:0] = status_reg;
            uacm_pkg::UACM_ADDR_IRQMSK: readMux[2:0] = mask_reg;
            default:                    readMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (setupPhase) begin
            prdata_reg  <= pwrite ? 32'h0 : readMux;
            pslverr_reg <= !mapped;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reload_read_a : assert property (setupPhase && !pwrite && paddr == uacm_pkg::UACM_ADDR_BRL
        && !ctl1_reg.baudTimerSelect |=> prdata[7:0] == brl_reg) // [RULE_01] [RULE_04]
        else $error("divisor read did not return reload");
    live_read_a : assert property (setupPhase && !pwrite && paddr == uacm_pkg::UACM_ADDR_BRH
        && ctl1_reg.baudTimerSelect |=> prdata[7:0] == $past(baudCount[15:8])) // [RULE_03] [RULE_05]
        else $error("divisor read did not return live count");
    timer_irq_a : assert property (baudZero && !rxOn && ctl1_reg.baudTimerSelect
        |=> status_reg[uacm_pkg::UACM_IRQ_TIMER]) // [RULE_02]
        else $error("timer zero did not set status");
    timer_quiet_a : assert property (rxOn && !(wrAccess && paddr == uacm_pkg::UACM_ADDR_CTL0)
        && !status_reg[uacm_pkg::UACM_IRQ_TIMER] |=> !status_reg[uacm_pkg::UACM_IRQ_TIMER]) // [RULE_04] [RULE_12]
        else $error("timer interrupt while receiving");
    suppress_data_a : assert property (ctl1_reg.dataIrqSuppress && !status_reg[uacm_pkg::UACM_IRQ_DATA]
        |=> !status_reg[uacm_pkg::UACM_IRQ_DATA]) // [RULE_07]
        else $error("suppressed data raised interrupt");
    data_irq_a : assert property (acceptByte && !ctl1_reg.mpEnable && !ctl1_reg.dataIrqSuppress
        |=> status_reg[uacm_pkg::UACM_IRQ_DATA]) // [RULE_06]
        else $error("received data did not interrupt");
    err_irq_a : assert property (errEvent |=> status_reg[uacm_pkg::UACM_IRQ_ERR]) // [RULE_06] [RULE_07]
        else $error("receiver error did not interrupt");
    mismatch_quiet_a : assert property (acceptByte && isAddr && ctl1_reg.mpModeHi && !addrMatch
        && !rxAvail_reg |=> !rxAvail_reg && !matched_reg) // [RULE_09] [RULE_10]
        else $error("mismatched address delivered");
    mode_data_a : assert property (acceptByte && ctl1_reg.mpEnable && mpMode == uacm_pkg::UACM_MP_DATA
        && isAddr && !status_reg[uacm_pkg::UACM_IRQ_DATA] |=> !status_reg[uacm_pkg::UACM_IRQ_DATA]) // [RULE_13]
        else $error("mode 11 interrupted on address");
    ir_route_a : assert property (ctl1_reg.infraredCodecOn |=> pinTxd == $past(txEncoded)) // [RULE_08]
        else $error("infrared route not taken");
    node_reset_a : assert property ($fell(rst) |-> nodeMatch_reg == 8'h00) // [RULE_11]
        else $error("node match not reset to zero");

    timer_cycle_c : cover property (status_reg[uacm_pkg::UACM_IRQ_TIMER] && irq);
    match_data_c  : cover property (matched_reg && acceptByte && !isAddr && deliver);
    err_only_c    : cover property (ctl1_reg.dataIrqSuppress && errEvent);
    slverr_c      : cover property (pslverr);

endmodule : uacm_top

/* File: dv/uacm_serial_node.sv */
/*
 * uacm_serial_node: far-side node, hands bytes and errors to the receive
 * side and stands in for the infrared codec.
 * assumes: bench calls send_byte and send_error; clk is the block clock.
 */
`timescale 1ns/100ps
module uacm_serial_node (
    input  wire logic                 clk,
    input  wire logic                 txRaw,
    output logic                      rxValid,
    output uacm_pkg::uacm_rxbyte_type rxByte,
    output logic                      rxError,
    output logic                      txEncoded,
    output logic                      pinRxd,
    output logic                      rxDecoded
);
    // ----------------------------------------
    // codec and line
    // ----------------------------------------
    // codec inverts so the two paths can be told apart
    assign txEncoded = ~txRaw;
    assign pinRxd    = txRaw;
    assign rxDecoded = ~txRaw;
    initial begin
        rxValid = 1'b0;
        rxError = 1'b0;
        rxByte  = '0;
    end
    task automatic send_byte(input logic nin, input logic [7:0] b);
        @(posedge clk);
        rxValid <= 1'b1;
        rxByte  <= {nin, b};
        @(posedge clk);
        rxValid <= 1'b0;
        // stale byte must not look valid
        rxByte  <= ~{nin, b};
    endtask : send_byte
    task automatic send_error();
        @(posedge clk);
        rxError <= 1'b1;
        @(posedge clk);
        rxError <= 1'b0;
    endtask : send_error
endmodule : uacm_serial_node

/* File: dv/testbench.sv */
/*
 * testbench: apb tasks and directed tests for uacm_top.
 * assumes: zero-wait apb slave, node model on the receive side.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, txRaw = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v1, v2;
    logic pready, pslverr, rxValid, rxError, rxEnable, rxDataAvail, txEncoded;
    logic pinTxd, pinRxd, rxDecoded, rxSerial, infraredCodecOn, irq;
    uacm_pkg::uacm_rxbyte_type rxByte;
    int mismatches = 0, check_count = 0;
    logic [7:0] mode [4] = '{8'h40, 8'h60, 8'hc0, 8'he0};
    logic [3:0] expv [4] = '{4'hf, 4'ha, 4'hc, 4'h4};
    localparam logic [15:0] A_C0 = uacm_pkg::UACM_ADDR_CTL0, A_C1 = uacm_pkg::UACM_ADDR_CTL1;
    localparam logic [15:0] A_ST = uacm_pkg::UACM_ADDR_IRQST, A_MSK = uacm_pkg::UACM_ADDR_IRQMSK;
    localparam logic [15:0] A_BRL = uacm_pkg::UACM_ADDR_BRL, A_RX = uacm_pkg::UACM_ADDR_RXDATA;
    always #5 clk = ~clk;
    uacm_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
        .prdata, .pready, .pslverr, .rxValid, .rxByte, .rxError, .rxEnable, .rxDataAvail,
        .txRaw, .txEncoded, .pinTxd, .pinRxd, .rxDecoded, .rxSerial, .infraredCodecOn, .irq);
    uacm_serial_node node_u (.clk, .txRaw, .rxValid, .rxByte, .rxError, .txEncoded,
        .pinRxd, .rxDecoded);
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] q);
        apb(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic rdchk(input string n, input logic [15:0] a, input logic [7:0] e);
        logic [31:0] q;
        rd(a, q);
        `CHK(n, {24'h0, e}, q)
    endtask : rdchk
    task automatic step(input string n, input logic nb, input logic [7:0] b,
                        input logic ea, input logic ei);
        rd(A_RX, v1);
        wr(A_ST, 8'h07);
        node_u.send_byte(nb, b);
        @(posedge clk);
        #1;
        `CHK(n, ea, rxDataAvail)
        `CHK(n, ei, irq)
    endtask : step
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("node_rst", uacm_pkg::UACM_ADDR_NODE, 8'h00);
        wr(uacm_pkg::UACM_ADDR_NODE, 8'h5a);
        rdchk("node_rw", uacm_pkg::UACM_ADDR_NODE, 8'h5a);
        wr(uacm_pkg::UACM_ADDR_BRH, 8'h00);
        wr(A_BRL, 8'h08);
        repeat (20) @(posedge clk);
        rdchk("brl_reload", A_BRL, 8'h08);
        rdchk("tmr_off", A_ST, 8'h00);
        wr(A_C1, 8'h04);
        rdchk("brh_live", uacm_pkg::UACM_ADDR_BRH, 8'h00);
        rd(A_BRL, v1);
        rd(A_BRL, v2);
        `CHK("brl_live", 1'b1, v1 != v2 && v1 <= 8)
        rdchk("tmr_irq", A_ST, 8'h04);
        wr(A_MSK, 8'h04);
        wr(A_ST, 8'h04);
        // period is eight cycles, so it must be back by now
        repeat (9) @(posedge clk);
        #1;
        `CHK("tmr_again", 1'b1, irq)
        wr(A_C0, 8'h40);
        wr(A_ST, 8'h07);
        repeat (20) @(posedge clk);
        `CHK("rx_en", 1'b1, rxEnable)
        rdchk("tmr_rxon", A_ST, 8'h00);
        rd(A_BRL, v1);
        rd(A_BRL, v2);
        `CHK("brl_rxon", 1'b1, v1 != v2)
        wr(A_C1, 8'h00);
        rdchk("brl_rxon0", A_BRL, 8'h08);
        wr(A_MSK, 8'h03);
        step("data_irq", 1'b0, 8'h11, 1'b1, 1'b1);
        wr(A_C1, 8'h02);
        step("data_supp", 1'b0, 8'h22, 1'b1, 1'b0);
        node_u.send_error();
        @(posedge clk);
        #1;
        `CHK("err_irq", 1'b1, irq)
        @(posedge clk);
        txRaw <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("txd_plain", 1'b1, pinTxd)
        `CHK("rxs_plain", 1'b1, rxSerial)
        wr(A_C1, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        `CHK("txd_ir", 1'b0, pinTxd)
        `CHK("rxs_ir", 1'b0, rxSerial)
        `CHK("ir_on", 1'b1, infraredCodecOn)
        foreach (mode[i]) begin
            wr(A_C1, mode[i]);
            // modes 0x store every byte, only the interrupt is gated
            step("mp_am", 1'b1, 8'h5a, expv[i][3] | ~mode[i][7], expv[i][3]);
            step("mp_d1", 1'b0, 8'h01, expv[i][2] | ~mode[i][7], expv[i][2]);
            step("mp_ax", 1'b1, 8'h33, expv[i][1] | ~mode[i][7], expv[i][1]);
            step("mp_d2", 1'b0, 8'h02, expv[i][0] | ~mode[i][7], expv[i][0]);
        end
        tally_and_finish();
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule : testbench
